// *** ata_dsp_drive_model.sv ***
// Behavioural drive on both channels
`timescale 1ns/1ps
module ata_dsp_drive_model (
  // Pins from the controller
  input  wire logic        clk_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [3:0]  sel_n_i,
  input  wire logic [1:0]  ack_n_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [15:0] data_i,
  // Test controls
  input  wire logic [7:0]  stretch_i,
  input  wire logic [1:0]  pend_i,
  input  wire logic [1:0]  irq_dis_i,
  input  wire logic [1:0]  xfer_rdy_i,
  // Pins to the controller
  output logic      [15:0] data_o,
  output logic             ready_o,
  output logic      [1:0]  irq_o,
  output logic      [1:0]  xreq_o
);
  logic [15:0] mem [32];
  logic [15:0] last_ff = 16'h0000;
  logic [7:0]  cnt_ff = 8'h00;
  logic [4:0]  idx;
  assign idx = {!ack_n_i[1] | !sel_n_i[2] | !sel_n_i[3], !sel_n_i[1] | !sel_n_i[3], addr_i};
  assign data_o = rd_n_i ? ~last_ff : (idx[3] | (addr_i != 3'h0)) ? {8'h5a, mem[idx][7:0]} : mem[idx];
  assign ready_o = (rd_n_i & wr_n_i) | (cnt_ff >= stretch_i);
  assign irq_o = pend_i & ~irq_dis_i;
  assign xreq_o = xfer_rdy_i;
  always @(posedge clk_i) begin
    cnt_ff <= (rd_n_i & wr_n_i) ? 8'h00 : cnt_ff + 8'h01;
    if (!rd_n_i) last_ff <= mem[idx];
  end
  always @(posedge wr_n_i) mem[idx] <= data_i;
endmodule : ata_dsp_drive_model

// *** ata_dsp_pin_if.sv ***
// Drive-side pin interface: strobe cycles, straps, resets, interrupts, transfer handshake
`timescale 1ns/1ps
`include "ata_dsp_regs.svh"
module ata_dsp_pin_if (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  // User request and answer
  input  wire logic                 req_valid_i,
  input  wire ata_dsp_pkg::ata_req_type req_i,
  output logic                      req_ready_o,
  output logic                      rsp_valid_o,
  output logic [15:0]               rsp_rdata_o,
  // Control and status
  input  wire logic                 sw_reset_i,
  output logic                      chip_enable_o,
  output logic [7:0]                prog_if_o,
  output logic                      test_mode_o,
  output logic                      out_en_o,
  output logic                      chan1_irq_state_o,
  output logic                      chan2_irq_state_o,
  output logic                      chan1_xfer_pending_o,
  output logic                      chan2_xfer_pending_o,
  // Drive data bus
  input  wire logic [15:0]          drive_data_bus_i,
  output logic [15:0]               drive_data_bus_o,
  output logic                      drive_data_bus_oe_o,
  // Drive address lines and straps
  input  wire logic [2:0]           drive_addr_i,
  output logic [2:0]                drive_addr_o,
  output logic                      drive_addr_oe_o,
  // Strobes, ready, reset
  input  wire logic                 drive_ready_in_i,
  output logic                      drive_read_strobe_n_o,
  output logic                      drive_write_strobe_n_o,
  output logic                      drive_reset_n_o,
  // Chip selects
  output logic                      chan1_cmd_block_sel_n_o,
  output logic                      chan1_ctl_block_sel_n_o,
  output logic                      chan2_cmd_block_sel_n_o,
  output logic                      chan2_ctl_block_sel_n_o,
  // Interrupts
  input  wire logic                 chan1_drive_irq_in_i,
  input  wire logic                 chan2_drive_irq_in_i,
  output logic                      irq14_o,
  output logic                      irq15_o,
  // Transfer handshake
  input  wire logic                 chan1_xfer_request_i,
  input  wire logic                 chan2_xfer_request_i,
  output logic                      chan1_xfer_ack_n_o,
  output logic                      chan2_xfer_ack_n_o
);
  import ata_dsp_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_wide(input ata_req_type r);
    is_wide = r.xfer | (~r.ctl_blk & (r.addr == `ATA_DATA_PORT));
  endfunction : is_wide

  localparam logic [3:0] SETUP_CYC  = 4'(`ATA_SETUP_CYC);
  localparam logic [3:0] ACTIVE_CYC = 4'(`ATA_ACTIVE_CYC);
  localparam logic [3:0] RECOV_CYC  = 4'(`ATA_RECOV_CYC);

  // ----------------------------------------------------------------
  // Straps
  // ----------------------------------------------------------------
  logic       strap_done_ff, nxt_strap_done;
  logic       test_mode_ff,  nxt_test_mode;
  logic       chip_en_ff,    nxt_chip_en;
  logic       native_ff,     nxt_native;

  always_comb begin
    nxt_strap_done = 1'b1;
    nxt_test_mode  = test_mode_ff;
    nxt_chip_en    = chip_en_ff;
    nxt_native     = native_ff;
    if (!strap_done_ff) begin
      nxt_test_mode = ~drive_addr_i[0];
      nxt_chip_en   = drive_addr_i[1];
      nxt_native    = drive_addr_i[2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_done_ff <= 1'b0;
      test_mode_ff  <= 1'b0;
      chip_en_ff    <= 1'b0;
      native_ff     <= 1'b0;
    end else begin
      strap_done_ff <= nxt_strap_done;
      test_mode_ff  <= nxt_test_mode;
      chip_en_ff    <= nxt_chip_en;
      native_ff     <= nxt_native;
    end
  end

  always_comb begin
    prog_if_o                  = 8'h00;
    prog_if_o[`ATA_PIF_LO_BIT] = native_ff;
    prog_if_o[`ATA_PIF_HI_BIT] = native_ff;
  end
  assign chip_enable_o = chip_en_ff;
  assign test_mode_o   = test_mode_ff;
  assign out_en_o      = strap_done_ff & ~test_mode_ff;

  // ----------------------------------------------------------------
  // Strobe cycle sequencer
  // ----------------------------------------------------------------
  ata_state_type state_ff, nxt_state;
  ata_req_type   req_ff,   nxt_req;
  logic [3:0]    cnt_ff,   nxt_cnt;
  logic [15:0]   rdata_ff, nxt_rdata;
  logic          rsp_ff,   nxt_rsp;

  assign req_ready_o = (state_ff == ST_IDLE) & out_en_o & chip_en_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_req   = req_ff;
    nxt_cnt   = cnt_ff;
    nxt_rdata = rdata_ff;
    nxt_rsp   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (req_valid_i && req_ready_o) begin
          nxt_req = req_i;
          if (!is_wide(req_i)) begin
            nxt_req.wdata[15:8] = 8'h00;
          end
          nxt_cnt   = SETUP_CYC;
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_ff <= 4'h1) begin
          nxt_cnt   = ACTIVE_CYC;
          nxt_state = ST_ACTIVE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      ST_ACTIVE: begin
        if (cnt_ff > 4'h1) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else if (drive_ready_in_i || req_ff.xfer) begin
          if (!req_ff.write) begin
            nxt_rdata = drive_data_bus_i;
            if (!is_wide(req_ff)) begin
              nxt_rdata[15:8] = 8'h00;
            end
          end
          nxt_rsp   = 1'b1;
          nxt_cnt   = RECOV_CYC;
          nxt_state = ST_RECOV;
        end
      end
      ST_RECOV: begin
        if (cnt_ff <= 4'h1) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_IDLE;
      req_ff   <= '0;
      cnt_ff   <= 4'h0;
      rdata_ff <= 16'h0000;
      rsp_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff   <= nxt_req;
      cnt_ff   <= nxt_cnt;
      rdata_ff <= nxt_rdata;
      rsp_ff   <= nxt_rsp;
    end
  end

  assign rsp_valid_o = rsp_ff;
  assign rsp_rdata_o = rdata_ff;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic busy;
  logic strobe_on;
  logic sel_on;

  assign busy      = (state_ff != ST_IDLE);
  assign strobe_on = (state_ff == ST_ACTIVE);
  assign sel_on    = busy & ~req_ff.xfer;

  assign drive_read_strobe_n_o  = ~(strobe_on & ~req_ff.write);
  assign drive_write_strobe_n_o = ~(strobe_on & req_ff.write);

  assign drive_data_bus_o    = req_ff.wdata;
  assign drive_data_bus_oe_o = out_en_o & req_ff.write & (state_ff != ST_IDLE);

  assign drive_addr_o    = req_ff.addr;
  assign drive_addr_oe_o = out_en_o;

  assign chan1_cmd_block_sel_n_o = ~(sel_on & ~req_ff.chan & ~req_ff.ctl_blk);
  assign chan1_ctl_block_sel_n_o = ~(sel_on & ~req_ff.chan & req_ff.ctl_blk);
  assign chan2_cmd_block_sel_n_o = ~(sel_on & req_ff.chan & ~req_ff.ctl_blk);
  assign chan2_ctl_block_sel_n_o = ~(sel_on & req_ff.chan & req_ff.ctl_blk);

  assign chan1_xfer_ack_n_o = ~(busy & req_ff.xfer & ~req_ff.chan);
  assign chan2_xfer_ack_n_o = ~(busy & req_ff.xfer & req_ff.chan);

  // ----------------------------------------------------------------
  // Drive reset, interrupts and transfer requests
  // ----------------------------------------------------------------
  logic       drv_rst_n_ff, nxt_drv_rst_n;
  logic [1:0] irq_ff,       nxt_irq;
  logic [1:0] xreq_ff,      nxt_xreq;

  always_comb begin
    nxt_drv_rst_n = ~sw_reset_i;
    nxt_irq       = {chan2_drive_irq_in_i, chan1_drive_irq_in_i};
    nxt_xreq      = {chan2_xfer_request_i, chan1_xfer_request_i};
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drv_rst_n_ff <= 1'b0;
      irq_ff       <= 2'h0;
      xreq_ff      <= 2'h0;
    end else begin
      drv_rst_n_ff <= nxt_drv_rst_n;
      irq_ff       <= nxt_irq;
      xreq_ff      <= nxt_xreq;
    end
  end

  assign drive_reset_n_o      = drv_rst_n_ff;
  assign chan1_irq_state_o    = irq_ff[0];
  assign chan2_irq_state_o    = irq_ff[1];
  assign irq14_o              = irq_ff[0] & ~native_ff;
  assign irq15_o              = irq_ff[1] & ~native_ff;
  assign chan1_xfer_pending_o = xreq_ff[0];
  assign chan2_xfer_pending_o = xreq_ff[1];
endmodule : ata_dsp_pin_if

// *** ata_dsp_pin_if_monitor.sv ***
// Checker of the drive-side pin behaviour
`timescale 1ns/1ps
module ata_dsp_pin_if_monitor (
  // Watched ports
  input wire logic clk_i, rst_b_i, sw_reset_i, drive_ready_in_i,
  input wire logic [7:0]  prog_if_o,
  input wire logic [15:0] drive_data_bus_o,
  input wire logic [2:0]  drive_addr_o,
  input wire logic test_mode_o, out_en_o, drive_data_bus_oe_o, drive_addr_oe_o,
  input wire logic chan1_irq_state_o, chan2_irq_state_o, irq14_o, irq15_o,
  input wire logic drive_read_strobe_n_o, drive_write_strobe_n_o, drive_reset_n_o,
  input wire logic chan1_cmd_block_sel_n_o, chan1_ctl_block_sel_n_o,
  input wire logic chan2_cmd_block_sel_n_o, chan2_ctl_block_sel_n_o,
  input wire logic chan1_xfer_ack_n_o, chan2_xfer_ack_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic c1, c2, ackn, strb, narrow;
  assign c1 = !chan1_cmd_block_sel_n_o | !chan1_ctl_block_sel_n_o;
  assign c2 = !chan2_cmd_block_sel_n_o | !chan2_ctl_block_sel_n_o;
  assign ackn = chan1_xfer_ack_n_o & chan2_xfer_ack_n_o;
  assign strb = !drive_read_strobe_n_o | !drive_write_strobe_n_o;
  assign narrow = !chan1_ctl_block_sel_n_o | !chan2_ctl_block_sel_n_o | ((c1 | c2) & (drive_addr_o != 3'h0));
  a_soft_reset: assert property (sw_reset_i |=> !drive_reset_n_o) else $error("drive reset missed");
  a_irq_route: assert property (irq14_o == (chan1_irq_state_o & !prog_if_o[0])
    && irq15_o == (chan2_irq_state_o & !prog_if_o[0])) else $error("irq route wrong");
  a_legacy_bits: assert property (prog_if_o == {5'h00, prog_if_o[0], 1'b0, prog_if_o[0]}) else $error("prog if");
  a_one_channel: assert property (strb |-> $onehot({c1, c2, !chan1_xfer_ack_n_o, !chan2_xfer_ack_n_o})
    && !(!drive_read_strobe_n_o && !drive_write_strobe_n_o)) else $error("strobe select");
  a_test_float: assert property (test_mode_o |-> !out_en_o && !drive_data_bus_oe_o && !drive_addr_oe_o)
    else $error("test float");
  a_addr_drive: assert property (drive_addr_oe_o == out_en_o) else $error("addr enable");
  a_addr_valid: assert property (strb |-> drive_addr_oe_o && $stable(drive_addr_o)) else $error("addr");
  a_ready_stretch: assert property (strb && !drive_ready_in_i && ackn
    |=> $stable({drive_read_strobe_n_o, drive_write_strobe_n_o})) else $error("no stretch");
  a_write_hold: assert property ($rose(drive_write_strobe_n_o) |-> drive_data_bus_oe_o
    && $stable(drive_data_bus_o)) else $error("write data");
  a_narrow_byte: assert property (drive_data_bus_oe_o && narrow |-> drive_data_bus_o[15:8] == 8'h00)
    else $error("upper byte");
  a_read_release: assert property (!drive_read_strobe_n_o |-> !drive_data_bus_oe_o) else $error("read oe");
  a_ack_no_sel: assert property (!ackn |-> !(c1 | c2)) else $error("ack with select");
endmodule : ata_dsp_pin_if_monitor
bind ata_dsp_pin_if ata_dsp_pin_if_monitor u_mon (.clk_i, .rst_b_i, .sw_reset_i, .drive_ready_in_i, .prog_if_o,
  .drive_data_bus_o, .drive_addr_o, .test_mode_o, .out_en_o, .drive_data_bus_oe_o, .drive_addr_oe_o,
  .chan1_irq_state_o, .chan2_irq_state_o, .irq14_o, .irq15_o, .drive_read_strobe_n_o, .drive_write_strobe_n_o,
  .drive_reset_n_o, .chan1_cmd_block_sel_n_o, .chan1_ctl_block_sel_n_o, .chan2_cmd_block_sel_n_o,
  .chan2_ctl_block_sel_n_o, .chan1_xfer_ack_n_o, .chan2_xfer_ack_n_o);

// *** ata_dsp_pin_if_tb_top.sv ***
// Testbench of the drive-side pin interface
`timescale 1ns/1ps
module ata_dsp_pin_if_tb_top;
  import ata_dsp_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0, sw_reset_i = 1'b0;
  ata_req_type req_i = '0;
  logic req_ready_o, rsp_valid_o, chip_enable_o, test_mode_o, out_en_o, chan1_irq_state_o, chan2_irq_state_o;
  logic chan1_xfer_pending_o, chan2_xfer_pending_o, drive_data_bus_oe_o, drive_addr_oe_o, irq14_o, irq15_o;
  logic drive_read_strobe_n_o, drive_write_strobe_n_o, drive_reset_n_o, chan1_xfer_ack_n_o, chan2_xfer_ack_n_o;
  logic chan1_cmd_block_sel_n_o, chan1_ctl_block_sel_n_o, chan2_cmd_block_sel_n_o, chan2_ctl_block_sel_n_o;
  wire  drive_ready_in_i, chan1_drive_irq_in_i, chan2_drive_irq_in_i, chan1_xfer_request_i, chan2_xfer_request_i;
  logic [15:0] rsp_rdata_o, drive_data_bus_i, drive_data_bus_o, d_m, got, w, e;
  logic [7:0]  prog_if_o, stretch = 8'h00;
  logic [2:0]  drive_addr_i, drive_addr_o, strap = 3'h3, a;
  logic [1:0]  pend = 2'h0, idis = 2'h3, xrdy = 2'h0;
  int failures = 0, comparisons = 0, lat;
  always #12.5 clk_i = ~clk_i;
  assign drive_data_bus_i = drive_data_bus_oe_o ? drive_data_bus_o : d_m;
  assign drive_addr_i = drive_addr_oe_o ? drive_addr_o : strap;
  ata_dsp_pin_if uut (.*);
  ata_dsp_drive_model drv (.clk_i(clk_i), .rd_n_i(drive_read_strobe_n_o), .wr_n_i(drive_write_strobe_n_o),
    .sel_n_i({chan2_ctl_block_sel_n_o, chan2_cmd_block_sel_n_o, chan1_ctl_block_sel_n_o, chan1_cmd_block_sel_n_o}),
    .ack_n_i({chan2_xfer_ack_n_o, chan1_xfer_ack_n_o}), .addr_i(drive_addr_o), .data_i(drive_data_bus_i),
    .stretch_i(stretch), .pend_i(pend), .irq_dis_i(idis), .xfer_rdy_i(xrdy), .data_o(d_m),
    .ready_o(drive_ready_in_i), .irq_o({chan2_drive_irq_in_i, chan1_drive_irq_in_i}),
    .xreq_o({chan2_xfer_request_i, chan1_xfer_request_i}));
  task automatic print_verdict();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] x);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic io(input logic x, c, k, input logic [2:0] ad, input logic wr, input logic [15:0] d);
    int n;
    @(negedge clk_i);
    req_i = '{x, c, k, ad, wr, d};
    req_valid_i = 1'b1;
    n = 0;
    do begin @(posedge clk_i); n++; end while (req_ready_o !== 1'b1 && n < 50);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    lat = 0;
    while (rsp_valid_o !== 1'b1 && lat < 100) begin @(negedge clk_i); lat++; end
    if (n >= 50 || lat >= 100) begin
      failures++;
      print_verdict();
    end else begin
      got = rsp_rdata_o;
    end
  endtask : io
  initial begin
    repeat (5) @(negedge clk_i);
    chk("reset_drv", drive_reset_n_o, 1'b0);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("chip_en", chip_enable_o, 1'b1);
    chk("prog_if", prog_if_o, 8'h00);
    chk("test_mode", test_mode_o, 1'b0);
    for (int i = 0; i < 5; i++) begin
      w = 16'hc3a5 ^ 16'(i << 4);
      e = (i == 4) ? w : {8'h00, w[7:0]};
      a = (i == 4) ? 3'h0 : 3'h6;
      io(1'b0, i[0], i[1], a, 1'b1, w);
      chk("drv_mem", drv.mem[{i[0], i[1], a}], e);
      io(1'b0, i[0], i[1], a, 1'b0, 16'h0000);
      chk("reg_rd", got, e);
      chk("latency", 16'(lat >= 9 && lat <= 12), 16'h0001);
    end
    stretch = 8'h14;
    io(1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 16'h0000);
    stretch = 8'h00;
    chk("stretch_rd", got, 16'hc3e5);
    chk("stretch_lat", 16'(lat >= 20), 16'h0001);
    xrdy = 2'h2;
    repeat (2) @(negedge clk_i);
    chk("xfer_pend", {chan2_xfer_pending_o, chan1_xfer_pending_o}, 2'h2);
    io(1'b1, 1'b1, 1'b0, 3'h0, 1'b1, 16'hbe6f);
    chk("xfer_wr", drv.mem[5'h10], 16'hbe6f);
    io(1'b1, 1'b1, 1'b0, 3'h0, 1'b0, 16'h0000);
    chk("xfer_rd", got, 16'hbe6f);
    pend = 2'h3;
    repeat (3) @(negedge clk_i);
    chk("irq_off", {irq15_o, irq14_o}, 2'h0);
    idis = 2'h0;
    repeat (3) @(negedge clk_i);
    chk("irq_on", {irq15_o, irq14_o}, 2'h3);
    sw_reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("sw_rst", drive_reset_n_o, 1'b0);
    sw_reset_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("sw_rel", drive_reset_n_o, 1'b1);
    rst_b_i = 1'b0;
    strap = 3'h4;
    repeat (2) @(negedge clk_i);
    chk("reset_mid", drive_reset_n_o, 1'b0);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("strap_test", {test_mode_o, out_en_o, drive_addr_oe_o}, 3'h4);
    chk("strap_ce", {chip_enable_o, req_ready_o}, 2'h0);
    chk("strap_pif", prog_if_o, 8'h05);
    chk("irq_native", {irq15_o, irq14_o}, 2'h0);
    print_verdict();
  end
endmodule : ata_dsp_pin_if_tb_top

// *** ata_dsp_pkg.sv ***
// Types of the drive-side pin interface
package ata_dsp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACTIVE,
    ST_RECOV
  } ata_state_type;

  typedef struct packed {
    logic        xfer;
    logic        chan;
    logic        ctl_blk;
    logic [2:0]  addr;
    logic        write;
    logic [15:0] wdata;
  } ata_req_type;
endpackage : ata_dsp_pkg

// *** ata_dsp_regs.svh ***
// Constants of the drive-side pin interface
`ifndef ATA_DSP_REGS_SVH
`define ATA_DSP_REGS_SVH
`define ATA_CLK_NS       25
`define ATA_T_SETUP_NS   70
`define ATA_T_ACTIVE_NS  165
`define ATA_T_RECOV_NS   30
`define ATA_SETUP_CYC    ((`ATA_T_SETUP_NS + `ATA_CLK_NS - 1) / `ATA_CLK_NS)
`define ATA_ACTIVE_CYC   ((`ATA_T_ACTIVE_NS + `ATA_CLK_NS - 1) / `ATA_CLK_NS)
`define ATA_RECOV_CYC    ((`ATA_T_RECOV_NS + `ATA_CLK_NS - 1) / `ATA_CLK_NS)
`define ATA_CMD_CE_BIT   0
`define ATA_PIF_LO_BIT   0
`define ATA_PIF_HI_BIT   2
`define ATA_DATA_PORT    3'h0
`endif
